// ### common/idcr_pkg.sv
/*
 * constants, field layout and carrier structs of the idle domain configuration register block.
 * assumes a wishbone classic slave with 32-bit data on a 100 mhz synchronous clock.
 */
// What this block does
// - config register decoded at word index 0x0001, sixteen bits wide.
// - bits 15-10 read zero; bits 9-0 read/write, reset to zero.
// - both clock generator idle bits zero keeps clock generator running.
// - both clock generator idle bits one, with every required bit set, stops clock generator at idle.
// - clock generator idle without extended bit raises bus error at idle.
// - clock generator idle with any required bit clear raises bus error.
// - bit 8 idles the instruction fetch port at next idle.
// - bit 7 zero keeps dma/host port active after idle.
// - bit 7 one disables dma/host port after idle.
// - writes take effect only when the next idle instruction executes.
// - bit 6 idles the i/o space port at next idle.
// - bit 5 idles the external memory interface at next idle.
package idcr_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  CONFIG_INDEX  = 8'h01;            // printed offset, word index
    localparam logic [7:0]  ACTIVE_INDEX  = 8'h02;            // applied settings, read only
    localparam logic [7:0]  IRQ_STATUS_INDEX = 8'h10;
    localparam logic [7:0]  IRQ_MASK_INDEX   = 8'h11;
    localparam int          ADDR_W        = 10;               // byte address bits decoded
    localparam logic [9:0]  CONFIG_RESET  = 10'h000;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;

    // field positions inside the config register
    localparam int CORE_BIT    = 0;
    localparam int MEMPORT_BIT = 1;
    localparam int CACHE_BIT   = 2;
    localparam int PERIPH_BIT  = 3;
    localparam int CLKGEN_BIT  = 4;
    localparam int EXTMEM_BIT  = 5;
    localparam int IOPORT_BIT  = 6;
    localparam int DMAPORT_BIT = 7;
    localparam int FETCH_BIT   = 8;
    localparam int CLKEXT_BIT  = 9;

    // bits that must accompany a clock generator idle: all but periph and clkgen itself
    localparam logic [9:0] CLKGEN_REQUIRED = 10'h3e7;

    // interrupt status bits
    localparam int IRQ_BUSERR_BIT = 0;                        // illegal clock generator idle
    localparam int IRQ_IDLE_BIT   = 1;                        // idle executed and applied

    typedef struct packed {
        logic        core_idle_request;
        logic        memory_port_idle_request;
        logic        instr_cache_idle_request;
        logic        io_block_domain_idle_request;
        logic        clkgen_stop;
        logic        ext_mem_iface_idle_request;
        logic        io_space_port_idle_request;
        logic        dma_host_port_idle_request;
        logic        fetch_port_idle_request;
    } idcr_domains_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [ADDR_W-1:0] adr;
        logic [31:0] dat;
    } idcr_wb_req_s;

endpackage

// ### dv/idle_domain_config_register_tb.sv
/*
 * self-checking bench for the idle domain configuration register block.
 * assumes the idcr_pkg package is compiled first and the top is idcr_top.
 */
`timescale 1ns/1ps
module idle_domain_config_register_tb;
    logic                    clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, idle_exec_i;
    logic [3:0]              wb_sel_i;
    logic [9:0]              wb_adr_i;
    logic [31:0]             wb_dat_i, wb_dat_o, rd;
    logic                    wb_ack_o, bus_error_o, irq_o;
    idcr_pkg::idcr_domains_s domains_o, last;
    int                      error_cnt, checks_done;

    idcr_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .idle_exec_i(idle_exec_i),
        .domains_o(domains_o), .bus_error_o(bus_error_o), .irq_o(irq_o));

    // ****************************************************************
    // helpers
    // ****************************************************************
    // free running 100 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // classic single cycle; waits for ack with no assumed latency, watchdog cuts a hang
    task automatic wb(input logic we, input logic [9:0] adr, input logic [3:0] sel, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    // write a setting, confirm it waits for the idle pulse, then apply and judge
    task automatic idle(input logic [9:0] c);
        idcr_pkg::idcr_domains_s exp;
        logic                    err;
        err = c[4] & ~(&{c[9:5], c[2:0]});
        exp = '{c[0], c[1], c[2], c[3], c[4] & ~err, c[5], c[6], c[7], c[8]};
        wb(1'b1, 10'h004, 4'h3, {22'h0, c});
        chk(domains_o === last, "domains moved before idle");
        @(posedge clk_i) idle_exec_i <= 1'b1;
        @(posedge clk_i) idle_exec_i <= 1'b0;
        #1;
        chk(domains_o === exp, "domains after idle");
        chk(bus_error_o === err, "bus error after idle");
        @(posedge clk_i) #1;
        chk(bus_error_o === 1'b0, "bus error not a pulse");
        last = exp;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // reset value, reserved bits, byte lanes, unmapped places
    task automatic t_regs();
        wb(1'b0, 10'h004, 4'h3, 32'h0);
        chk(rd === 32'h0, "config reset value");
        wb(1'b1, 10'h004, 4'hf, 32'hffff_ffff);
        wb(1'b0, 10'h004, 4'h3, 32'h0);
        chk(rd === 32'h0000_03ff, "reserved bits not zero");
        wb(1'b1, 10'h004, 4'h1, 32'h0);
        wb(1'b0, 10'h004, 4'h3, 32'h0);
        chk(rd === 32'h0000_0300, "lane zero write");
        wb(1'b0, 10'h006, 4'h3, 32'h0);
        chk(rd === 32'h0, "misaligned read");
        wb(1'b0, 10'h000, 4'h3, 32'h0);
        chk(rd === 32'h0, "unmapped read");
    endtask

    // each single domain bit, then clock generator combinations
    task automatic t_idle();
        for (int b = 0; b < 10; b++) begin
            if (b != 4) idle(10'h001 << b);
        end
        idle(10'h000);
        idle(10'h3f7);
        idle(10'h010);
        idle(10'h2f7);
        idle(10'h3ff);
        wb(1'b0, 10'h008, 4'h3, 32'h0);
        chk(rd[8:0] === last, "applied readback");
    endtask

    task automatic t_irq();
        wb(1'b0, 10'h040, 4'h1, 32'h0);
        chk(rd[1:0] === 2'h3, "status sticky");
        chk(irq_o === 1'b0, "irq while masked");
        wb(1'b1, 10'h044, 4'h1, 32'h1);
        chk(irq_o === 1'b1, "irq unmasked");
        wb(1'b1, 10'h040, 4'h1, 32'h1);
        chk(irq_o === 1'b0, "irq after clear");
        idle(10'h010);
        chk(irq_o === 1'b1, "irq on new error");
        wb(1'b1, 10'h040, 4'h1, 32'h3);
        wb(1'b0, 10'h040, 4'h1, 32'h0);
        chk(rd[1:0] === 2'h0 && irq_o === 1'b0, "status clear");
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        error_cnt = 0;
        checks_done = 0;
        last = '0;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, idle_exec_i} = 5'h10;
        wb_sel_i = 4'h0;
        wb_adr_i = 10'h000;
        wb_dat_i = 32'h0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(domains_o === last && irq_o === 1'b0, "reset outputs");
        t_regs();
        t_idle();
        t_irq();
        give_verdict();
    end

    // the run needs well under a thousand cycles; this is ample margin
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end
endmodule

// ### hdl/idcr_check.sv
/*
 * combinational legality check of an idle request set against the clock generator rules.
 * assumes the stored config value arrives from a register on the same clock.
 */
`timescale 1ns/1ps
module idcr_check (
    input  wire logic [9:0]          cfg_i,
    output wire idcr_pkg::idcr_domains_s dom_o,
    output wire logic                illegal_o
);

    logic clk_req;
    logic clk_ext;

    assign clk_req = cfg_i[idcr_pkg::CLKGEN_BIT];
    assign clk_ext = cfg_i[idcr_pkg::CLKEXT_BIT];

    // illegal clock idle
    // a clock idle without every companion bit would strand a domain on a dead clock
    assign illegal_o = clk_req
        && ((cfg_i & idcr_pkg::CLKGEN_REQUIRED) != idcr_pkg::CLKGEN_REQUIRED);

    assign dom_o.clkgen_stop                  = clk_req && clk_ext && !illegal_o;
    assign dom_o.core_idle_request            = cfg_i[idcr_pkg::CORE_BIT];
    assign dom_o.memory_port_idle_request     = cfg_i[idcr_pkg::MEMPORT_BIT];
    assign dom_o.instr_cache_idle_request     = cfg_i[idcr_pkg::CACHE_BIT];
    assign dom_o.io_block_domain_idle_request = cfg_i[idcr_pkg::PERIPH_BIT];
    assign dom_o.ext_mem_iface_idle_request   = cfg_i[idcr_pkg::EXTMEM_BIT];
    assign dom_o.io_space_port_idle_request   = cfg_i[idcr_pkg::IOPORT_BIT];
    assign dom_o.dma_host_port_idle_request   = cfg_i[idcr_pkg::DMAPORT_BIT];
    assign dom_o.fetch_port_idle_request      = cfg_i[idcr_pkg::FETCH_BIT];

endmodule

// ### hdl/idcr_top.sv
/*
 * idle domain configuration register: wishbone slave, idle application and bus error interrupt.
 * assumes idle_exec_i is a one-cycle pulse from core logic on clk_i, and a synchronous reset.
 */
`timescale 1ns/1ps
module idcr_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [9:0]              wb_adr_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    idle_exec_i,
    output idcr_pkg::idcr_domains_s      domains_o,
    output logic                         bus_error_o,
    output logic                         irq_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [9:0]              cfg;
        idcr_pkg::idcr_domains_s active;
        logic                    buserr_pulse;
        logic [1:0]              irq_status;
        logic [1:0]              irq_mask;
        logic                    ack;
        logic [31:0]             rdata;
    } idcr_state_s;

    idcr_state_s             st_reg;
    idcr_state_s             st_next;
    idcr_pkg::idcr_domains_s chk_dom;
    logic                    chk_illegal;
    logic                    access;
    logic [7:0]              index;
    logic                    addr_aligned;
    logic                    irq_status_err;
    logic                    status_clear0;

    // legality check runs on the stored value, not on bus data in flight
    idcr_check u_check (
        .cfg_i     (st_reg.cfg),
        .dom_o     (chk_dom),
        .illegal_o (chk_illegal)
    );

    // ****************************************************************
    // bus decode
    // ****************************************************************
    // the ack register doubles as the guard that drops ack one cycle after it rose
    assign access       = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign index        = wb_adr_i[9:2];
    assign addr_aligned = (wb_adr_i[1:0] == 2'h0);

    // helper views for the checks below
    assign irq_status_err = st_reg.irq_status[idcr_pkg::IRQ_BUSERR_BIT];
    assign status_clear0  = access && wb_we_i && addr_aligned && wb_sel_i[0] && wb_dat_i[0]
                            && (index == idcr_pkg::IRQ_STATUS_INDEX);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next              = st_reg;
        st_next.ack          = access;
        st_next.buserr_pulse = 1'b0;
        st_next.rdata        = 32'h0000_0000;

        // register writes: low lanes only carry the sixteen bit register
        if (access && wb_we_i && addr_aligned) begin
            case (index)
                idcr_pkg::CONFIG_INDEX: begin
                    if (wb_sel_i[0]) begin
                        st_next.cfg[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        st_next.cfg[9:8] = wb_dat_i[9:8];
                    end
                end
                idcr_pkg::IRQ_MASK_INDEX: begin
                    if (wb_sel_i[0]) begin
                        st_next.irq_mask = wb_dat_i[1:0];
                    end
                end
                idcr_pkg::IRQ_STATUS_INDEX: begin
                    if (wb_sel_i[0]) begin
                        st_next.irq_status = st_reg.irq_status & ~wb_dat_i[1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads; unmapped words read as zero and still acknowledge
        if (access && !wb_we_i && addr_aligned) begin
            case (index)
                idcr_pkg::CONFIG_INDEX:     st_next.rdata = {22'h000000, st_reg.cfg};
                idcr_pkg::ACTIVE_INDEX:     st_next.rdata = {23'h000000, st_reg.active};
                idcr_pkg::IRQ_STATUS_INDEX: st_next.rdata = {30'h00000000, st_reg.irq_status};
                idcr_pkg::IRQ_MASK_INDEX:   st_next.rdata = {30'h00000000, st_reg.irq_mask};
                default:                    st_next.rdata = 32'h0000_0000;
            endcase
        end

        if (idle_exec_i) begin
            st_next.active       = chk_dom;
            st_next.buserr_pulse = chk_illegal;
            // set wins over a same-cycle software clear
            st_next.irq_status[idcr_pkg::IRQ_IDLE_BIT] = 1'b1;
            if (chk_illegal) begin
                st_next.irq_status[idcr_pkg::IRQ_BUSERR_BIT] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // single register stage; reset clears every control bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg            <= '0;
            st_reg.cfg        <= idcr_pkg::CONFIG_RESET;
            st_reg.irq_status <= idcr_pkg::IRQ_RESET;
            st_reg.irq_mask   <= idcr_pkg::IRQ_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign wb_ack_o    = st_reg.ack;
    assign wb_dat_o    = st_reg.rdata;
    assign domains_o   = st_reg.active;
    assign bus_error_o = st_reg.buserr_pulse;
    assign irq_o       = |(st_reg.irq_status & st_reg.irq_mask);

    // ****************************************************************
    // checks
    // ****************************************************************
    // readback of config
    a_cfg_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 10'h004)
        |=> (wb_ack_o && wb_dat_o == {22'h000000, $past(st_reg.cfg)}))
        else $error("config readback wrong");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && $past(wb_adr_i) == 10'h004) |-> (wb_dat_o[31:10] == 22'h000000))
        else $error("reserved bits not zero");
    a_clk_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (idle_exec_i && st_reg.cfg == 10'h3ff) |=> domains_o.clkgen_stop)
        else $error("clock generator not stopped");
    a_clk_runs: assert property (@(posedge clk_i) disable iff (rst_i)
        (idle_exec_i && !st_reg.cfg[4] && !st_reg.cfg[9]) |=> !domains_o.clkgen_stop && !bus_error_o)
        else $error("clock generator stopped wrongly");
    a_ext_missing: assert property (@(posedge clk_i) disable iff (rst_i)
        (idle_exec_i && st_reg.cfg[4] && !st_reg.cfg[9]) |=> bus_error_o ##1 !bus_error_o)
        else $error("no bus error for missing extended bit");
    a_companion: assert property (@(posedge clk_i) disable iff (rst_i)
        (idle_exec_i && st_reg.cfg[4] && !st_reg.cfg[8]) |=> bus_error_o && irq_status_err)
        else $error("no bus error for missing companion bit");
    a_write_defers: assert property (@(posedge clk_i) disable iff (rst_i)
        (!idle_exec_i) |=> $stable(domains_o))
        else $error("domains changed without idle");
    a_dma_port: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> (domains_o.dma_host_port_idle_request == $past(st_reg.cfg[7])))
        else $error("dma port request not applied");

    // ****************************************************************
    // bus handshake checks
    // ****************************************************************
    // answer comes one cycle after the request is taken
    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged");

    // ack is a one-cycle pulse even with strobe held
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    // read data idles at zero so a late sample shows nothing stale
    a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data not zero outside ack");

    // misaligned reads answer zero
    a_misaligned: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && $past(wb_adr_i[1:0]) != 2'h0) |-> (wb_dat_o == 32'h0000_0000))
        else $error("misaligned read not zero");

    // full write lands in the writable field only
    a_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (access && wb_we_i && addr_aligned && index == idcr_pkg::CONFIG_INDEX && wb_sel_i[1:0] == 2'h3)
        |=> (st_reg.cfg == $past(wb_dat_i[9:0])))
        else $error("config write wrong");

    // config moves only on a bus write
    a_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(access && wb_we_i) |=> $stable(st_reg.cfg))
        else $error("config changed without write");

    // reset returns every output to zero
    a_reset_clears: assert property (@(posedge clk_i)
        rst_i |=> (!wb_ack_o && domains_o == '0 && !bus_error_o && !irq_o && st_reg.cfg == 10'h000))
        else $error("reset did not clear");

    // ****************************************************************
    // idle application checks
    // ****************************************************************
    // fetch port request applied at idle
    a_fetch_port: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> (domains_o.fetch_port_idle_request == $past(st_reg.cfg[8])))
        else $error("fetch port request not applied");

    // dma host port stays active when its bit is clear
    a_dma_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        (idle_exec_i && !st_reg.cfg[7]) |=> !domains_o.dma_host_port_idle_request)
        else $error("dma port idled wrongly");

    // i/o space port request applied at idle
    a_io_port: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> (domains_o.io_space_port_idle_request == $past(st_reg.cfg[6])))
        else $error("io space port request not applied");

    // external memory request applied at idle
    a_ext_mem: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> (domains_o.ext_mem_iface_idle_request == $past(st_reg.cfg[5])))
        else $error("external memory request not applied");

    // low domain requests applied at idle
    a_core_req: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> (domains_o.core_idle_request == $past(st_reg.cfg[0])))
        else $error("core request not applied");

    a_memport_req: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> (domains_o.memory_port_idle_request == $past(st_reg.cfg[1])))
        else $error("memory port request not applied");

    a_cache_req: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> (domains_o.instr_cache_idle_request == $past(st_reg.cfg[2])))
        else $error("cache request not applied");

    a_periph_req: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> (domains_o.io_block_domain_idle_request == $past(st_reg.cfg[3])))
        else $error("peripheral request not applied");

    // without the extended bit the clock generator never stops
    a_ext_required: assert property (@(posedge clk_i) disable iff (rst_i)
        (idle_exec_i && !st_reg.cfg[9]) |=> !domains_o.clkgen_stop)
        else $error("clock generator stopped without extended bit");

    // an illegal set never stops the clock generator
    a_illegal_runs: assert property (@(posedge clk_i) disable iff (rst_i)
        (idle_exec_i && chk_illegal) |=> !domains_o.clkgen_stop)
        else $error("clock generator stopped on illegal set");

    // bus error only follows an illegal idle
    a_buserr_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_error_o |-> ($past(idle_exec_i) && $past(chk_illegal)))
        else $error("bus error without illegal idle");

    // ****************************************************************
    // interrupt checks
    // ****************************************************************
    // a bus error always lands in the status register
    a_irq_buserr: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_error_o |-> irq_status_err)
        else $error("bus error not recorded");

    // status stays set until software writes a one to it
    a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (irq_status_err && !status_clear0) |=> irq_status_err)
        else $error("bus error status lost");

    // the idle status bit rises only on an idle instruction
    a_idle_status: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(st_reg.irq_status[idcr_pkg::IRQ_IDLE_BIT]) |-> $past(idle_exec_i))
        else $error("idle status set without idle");

    // every idle marks the idle status bit
    a_idle_marks: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_exec_i |=> st_reg.irq_status[idcr_pkg::IRQ_IDLE_BIT])
        else $error("idle status not set");

    // a fully masked block stays quiet
    a_mask_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.irq_mask == 2'h0) |-> !irq_o)
        else $error("irq while fully masked");

endmodule
